// *** rtl/dalu_consts.svh ***
// constants for the accumulator datapath
`ifndef DALU_CONSTS_SVH
`define DALU_CONSTS_SVH
`define DALU_WORD_W 16
`define DALU_ACC_W 32
`define DALU_SCALE_CNT_W 5
`define DALU_STORE_CNT_W 3
`define DALU_RSHIFT_CNT_W 4
`define DALU_DYN_CNT_W 4
`define DALU_ACC_RST 32'h0000_0000
`endif

// *** rtl/dalu_pkg.sv ***
// types for the accumulator datapath
package dalu_pkg;
  typedef enum logic [3:0] {
    DALU_OP_NOP      = 4'h0,
    DALU_OP_LOAD     = 4'h1,
    DALU_OP_ADD      = 4'h2,
    DALU_OP_SUB      = 4'h3,
    DALU_OP_AND      = 4'h4,
    DALU_OP_OR       = 4'h5,
    DALU_OP_XOR      = 4'h6,
    DALU_OP_NORMALISE_OP     = 4'h7,
    DALU_OP_RSHIFT   = 4'h8,
    DALU_OP_SAVE_BUF = 4'h9,
    DALU_OP_CMP_MIN  = 4'ha,
    DALU_OP_CMP_MAX  = 4'hb
  } dalu_op_e;
  typedef enum logic [1:0] {
    DALU_SRC_SCALE   = 2'h0,
    DALU_SRC_PRODUCT = 2'h1,
    DALU_SRC_BUFFER  = 2'h2
  } dalu_src_e;
  typedef struct packed {
    logic valid;
    dalu_op_e op;
    dalu_src_e src;
    logic use_imm;
    logic dyn_shift;
    logic [4:0] scale_cnt;
    logic [3:0] rshift_m1;
  } dalu_cmd_s;
  typedef struct packed {
    logic valid;
    logic high_half;
    logic [2:0] shift;
  } dalu_store_s;
endpackage : dalu_pkg

// *** rtl/dalu_scaler.sv ***
// input scaling shifter: 16-bit word to 32 bits, left shift 0..16
`timescale 1ns/1ns
`default_nettype none
`include "dalu_consts.svh"
module dalu_scaler
  import dalu_pkg::*;
(
  input wire logic [15:0] i_word,
  input wire logic [4:0] i_cnt,
  input wire logic i_sign_extend_mode_bit,
  output logic [31:0] o_value
);
  logic [31:0] widened;
  logic [4:0] cnt_sat;
  always_comb begin
    // upper bits zero or sign per mode bit widen to 32 bits
    widened = {{16{i_sign_extend_mode_bit & i_word[15]}}, i_word};
    // counts above 16 are clamped, never wrap into odd results
    cnt_sat = (i_cnt > 5'd16) ? 5'd16 : i_cnt;
    // low bits zero-filled by the shift
    o_value = widened << cnt_sat;
  end
endmodule : dalu_scaler
`default_nettype wire

// *** rtl/dalu_datapath.sv ***
// 32-bit alu, accumulator, buffer and store-path shifters
`timescale 1ns/1ns
`default_nettype none
`include "dalu_consts.svh"
// Operation
// - alu operand a is the accumulator; b is product, buffer or scaler
// - 16-bit memory or immediate words are widened to 32 bits
// - logic as well as arithmetic ops, each finished in one cycle
// - every alu result except save-buffer is written back into the accumulator
// - accumulator stored as separate high and low 16-bit halves
// - store path shifts left 0..7, accumulator unchanged
// - high-half store drops top bits, fills from upper low-half bits
// - low-half store fills vacated low bits with zeros
// - variable-shift add, load, subtract use four low bits of shift register
// - normalise op shifts the accumulator left
// - accumulator right shift by 1..16 in one cycle
// - 32-bit buffer saves the accumulator and serves as operand
// - min/max compare writes extreme to both, carry 1 when condition holds
// - scaler widens 16-bit bus word, shifts left 0..16, zero low fill
// - scaler upper bits zero or sign per sign-extend mode bit
module dalu_datapath
  import dalu_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire dalu_cmd_s i_cmd,
  input wire logic [15:0] i_mem_word,
  input wire logic [15:0] i_imm_word,
  input wire logic [31:0] i_product_reg,
  input wire logic [15:0] i_dynamic_shift_count_reg,
  input wire logic [15:0] i_status_reg_one,
  input wire logic [3:0] i_sxm_pos,
  input wire dalu_store_s i_store,
  output logic [31:0] o_accumulator,
  output logic [31:0] o_accumulator_buffer,
  output logic o_carry,
  output logic o_store_valid,
  output logic [15:0] o_store_data
);
  logic [31:0] accumulator_reg;
  logic [31:0] accumulator_next;
  logic [31:0] buffer_reg;
  logic [31:0] buffer_next;
  logic carry_reg;
  logic carry_next;
  logic store_valid_reg;
  logic [15:0] store_data_reg;
  logic [15:0] in_word;
  logic [4:0] scale_cnt;
  logic [31:0] scaled;
  logic [31:0] operand_b;
  logic sign_extend_mode_bit;
  logic is_less;

  // signed compare, shared by both min and max
  function automatic logic sgn_lt(input logic [31:0] a, input logic [31:0] b);
    sgn_lt = $signed(a) < $signed(b);
  endfunction : sgn_lt

  // upper-bit store shifter: source word, fill word, left shift 0..7
  function automatic logic [15:0] store_shift(input logic [15:0] hi, input logic [15:0] lo,
                                              input logic [2:0] sh);
    logic [31:0] wide;
    wide = {hi, lo} << sh;
    store_shift = wide[31:16];
  endfunction : store_shift

  assign sign_extend_mode_bit = i_status_reg_one[i_sxm_pos];
  assign in_word = i_cmd.use_imm ? i_imm_word : i_mem_word;
  // variable-shift ops take the count from four low bits
  assign scale_cnt = i_cmd.dyn_shift ? {1'b0, i_dynamic_shift_count_reg[3:0]} : i_cmd.scale_cnt;
  assign is_less = sgn_lt(accumulator_reg, buffer_reg);

  dalu_scaler u_scaler (
    .i_word(in_word),
    .i_cnt(scale_cnt),
    .i_sign_extend_mode_bit(sign_extend_mode_bit),
    .o_value(scaled)
  );

  always_comb begin
    // operand a is always the accumulator; b is one of three
    unique case (i_cmd.src)
      DALU_SRC_PRODUCT: operand_b = i_product_reg;
      DALU_SRC_BUFFER: operand_b = buffer_reg;
      default: operand_b = scaled;
    endcase
  end

  always_comb begin
    accumulator_next = accumulator_reg;
    buffer_next = buffer_reg;
    carry_next = carry_reg;
    if (i_cmd.valid) begin
      // all results except save-buffer land in the accumulator within this cycle; save writes the buffer only
      unique case (i_cmd.op)
        DALU_OP_LOAD: accumulator_next = operand_b;
        DALU_OP_ADD: accumulator_next = accumulator_reg + operand_b;
        DALU_OP_SUB: accumulator_next = accumulator_reg - operand_b;
        DALU_OP_AND: accumulator_next = accumulator_reg & operand_b;
        DALU_OP_OR: accumulator_next = accumulator_reg | operand_b;
        DALU_OP_XOR: accumulator_next = accumulator_reg ^ operand_b;
        DALU_OP_NORMALISE_OP: begin
          // one step per op; software repeats until sign and next bit differ
          if (accumulator_reg[31] == accumulator_reg[30]) begin
            accumulator_next = accumulator_reg << 1;
          end
        end
        DALU_OP_RSHIFT: accumulator_next = accumulator_reg >> (5'd1 + {1'b0, i_cmd.rshift_m1});
        DALU_OP_SAVE_BUF: buffer_next = accumulator_reg;
        DALU_OP_CMP_MIN: begin
          carry_next = is_less;
          accumulator_next = is_less ? accumulator_reg : buffer_reg;
          buffer_next = accumulator_next;
        end
        DALU_OP_CMP_MAX: begin
          carry_next = sgn_lt(buffer_reg, accumulator_reg);
          accumulator_next = carry_next ? accumulator_reg : buffer_reg;
          buffer_next = accumulator_next;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      accumulator_reg <= `DALU_ACC_RST;
      buffer_reg <= `DALU_ACC_RST;
      carry_reg <= 1'b0;
    end else begin
      accumulator_reg <= accumulator_next;
      buffer_reg <= buffer_next;
      carry_reg <= carry_next;
    end
  end

  // store path reads the accumulator only, so it is never disturbed
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      store_valid_reg <= 1'b0;
      store_data_reg <= 16'h0000;
    end else begin
      store_valid_reg <= i_store.valid;
      if (i_store.valid) begin
        if (i_store.high_half) begin
          store_data_reg <= store_shift(accumulator_reg[31:16], accumulator_reg[15:0], i_store.shift);
        end else begin
          store_data_reg <= store_shift(accumulator_reg[15:0], 16'h0000, i_store.shift);
        end
      end
    end
  end

  assign o_accumulator = accumulator_reg;
  assign o_accumulator_buffer = buffer_reg;
  assign o_carry = carry_reg;
  assign o_store_valid = store_valid_reg;
  assign o_store_data = store_data_reg;

  sequence s_min_cmd;
    i_cmd.valid && i_cmd.op == DALU_OP_CMP_MIN;
  endsequence
  sequence s_max_cmd;
    i_cmd.valid && i_cmd.op == DALU_OP_CMP_MAX;
  endsequence

  property p_add_result;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cmd.valid && i_cmd.op == DALU_OP_ADD) |=> accumulator_reg == $past(accumulator_reg) + $past(operand_b);
  endproperty
  a_add_result: assert property (p_add_result) else $error("add result wrong");

  property p_buf_operand;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cmd.valid && i_cmd.op == DALU_OP_LOAD && i_cmd.src == DALU_SRC_BUFFER) |=> accumulator_reg == $past(buffer_reg);
  endproperty
  a_buf_operand: assert property (p_buf_operand) else $error("buffer operand not loaded");

  property p_dyn_load;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cmd.valid && i_cmd.op == DALU_OP_LOAD && i_cmd.src == DALU_SRC_SCALE && i_cmd.dyn_shift && !i_cmd.use_imm
       && !sign_extend_mode_bit)
      |=> accumulator_reg == ({16'h0000, $past(i_mem_word)} << $past(i_dynamic_shift_count_reg[3:0]));
  endproperty
  a_dyn_load: assert property (p_dyn_load) else $error("variable shift load wrong");

  property p_store_accum_kept;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_store.valid && !i_cmd.valid) |=> accumulator_reg == $past(accumulator_reg);
  endproperty
  a_store_accum_kept: assert property (p_store_accum_kept) else $error("store changed accumulator");

  property p_store_high;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_store.valid && i_store.high_half && !i_cmd.valid)
      |=> o_store_valid && o_store_data == (($past(accumulator_reg) << $past(i_store.shift)) >> 16);
  endproperty
  a_store_high: assert property (p_store_high) else $error("high half store wrong");

  property p_store_low_zero;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_store.valid && !i_store.high_half)
      |=> o_store_data == ($past(accumulator_reg[15:0]) << $past(i_store.shift));
  endproperty
  a_store_low_zero: assert property (p_store_low_zero) else $error("low store fill not zero");

  property p_min_both;
    @(posedge i_clk_sys) disable iff (i_srst)
      s_min_cmd |=> accumulator_reg == buffer_reg && o_carry == ($signed($past(accumulator_reg)) < $signed($past(buffer_reg)));
  endproperty
  a_min_both: assert property (p_min_both) else $error("min compare wrong");

  // a failed compare must hand the retained extreme to both registers
  property p_min_fail;
    @(posedge i_clk_sys) disable iff (i_srst)
      s_min_cmd ##0 !is_less
      |=> !o_carry && accumulator_reg == $past(buffer_reg) && buffer_reg == $past(buffer_reg);
  endproperty
  a_min_fail: assert property (p_min_fail) else $error("failed min compare wrong");

  property p_max_keep;
    @(posedge i_clk_sys) disable iff (i_srst)
      s_max_cmd ##0 (!is_less && accumulator_reg != buffer_reg) |=> o_carry && buffer_reg == $past(accumulator_reg);
  endproperty
  a_max_keep: assert property (p_max_keep) else $error("max compare wrong");

  property p_rshift;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_cmd.valid && i_cmd.op == DALU_OP_RSHIFT && i_cmd.rshift_m1 == 4'hf) |=> accumulator_reg[31:16] == 16'h0000;
  endproperty
  a_rshift: assert property (p_rshift) else $error("right shift by 16 wrong");
endmodule : dalu_datapath
`default_nettype wire

// *** tb/dalu_cpu_model.sv ***
// decode and data bus model feeding the datapath
`timescale 1ns/1ns
`default_nettype none
module dalu_cpu_model
  import dalu_pkg::*;
(
  input wire logic i_clk_sys,
  output var dalu_cmd_s o_cmd,
  output logic [15:0] o_mem_word,
  output logic [15:0] o_imm_word,
  output logic [31:0] o_product_reg,
  output logic [15:0] o_dyn_reg,
  output logic [15:0] o_status_reg_one,
  output logic [3:0] o_sxm_pos,
  output var dalu_store_s o_store
);
  initial begin
    o_cmd = '0;
    o_store = '0;
    o_mem_word = 16'h0000;
    o_imm_word = 16'h0000;
    o_product_reg = 32'h0000_0000;
    o_dyn_reg = 16'h0000;
    o_status_reg_one = 16'h0000;
    o_sxm_pos = 4'ha;
  end
  task automatic set_mode(input logic [15:0] dyn, input logic [15:0] st);
    o_dyn_reg <= dyn;
    o_status_reg_one <= st;
  endtask : set_mode
  // one request, held only for the edge that takes it
  task automatic issue(input dalu_cmd_s c, input dalu_store_s s, input logic [15:0] w, input logic [31:0] p);
    @(posedge i_clk_sys);
    o_cmd <= c;
    o_store <= s;
    o_mem_word <= c.use_imm ? ~w : w;
    o_imm_word <= c.use_imm ? w : ~w;
    o_product_reg <= p;
    @(posedge i_clk_sys);
    o_cmd <= '0;
    o_store <= '0;
    // released bus shows inverted data, not the stale word
    o_mem_word <= ~o_mem_word;
    o_imm_word <= ~o_imm_word;
  endtask : issue
endmodule : dalu_cpu_model
`default_nettype wire

// *** tb/dalu_datapath_test.sv ***
// self-checking bench for the accumulator datapath
`timescale 1ns/1ns
`default_nettype none
module dalu_datapath_test
  import dalu_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  dalu_cmd_s cmd;
  dalu_store_s st;
  logic [15:0] mem, imm, dyn, stat;
  logic [31:0] prod, acc, buff, sdat_w;
  logic [3:0] pos;
  logic carry, svld;
  logic [15:0] sdat;
  int miscompares = 0;
  int total_checks = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  assign sdat_w = {16'h0000, sdat};
  dalu_cpu_model u_dalu_cpu_model (.i_clk_sys(i_clk_sys), .o_cmd(cmd), .o_mem_word(mem), .o_imm_word(imm),
    .o_product_reg(prod), .o_dyn_reg(dyn), .o_status_reg_one(stat), .o_sxm_pos(pos), .o_store(st));
  dalu_datapath u_dalu_datapath (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cmd(cmd), .i_mem_word(mem),
    .i_imm_word(imm), .i_product_reg(prod), .i_dynamic_shift_count_reg(dyn), .i_status_reg_one(stat),
    .i_sxm_pos(pos), .i_store(st), .o_accumulator(acc), .o_accumulator_buffer(buff), .o_carry(carry),
    .o_store_valid(svld), .o_store_data(sdat));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input dalu_op_e o, input dalu_src_e s, input logic im, input logic dy, input logic [4:0] n,
    input logic [3:0] m1, input logic [15:0] w, input logic [31:0] p);
    u_dalu_cpu_model.issue('{1'b1, o, s, im, dy, n, m1}, '0, w, p);
    #1;
  endtask : op
  task automatic ld(input logic [31:0] v);
    op(DALU_OP_LOAD, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0000, v);
  endtask : ld
  task automatic t_scale();
    u_dalu_cpu_model.set_mode(16'h0000, 16'h0400);
    op(DALU_OP_LOAD, DALU_SRC_SCALE, 1'b0, 1'b0, 5'h04, 4'h0, 16'h8001, 32'h0);
    chk(acc, 32'hfff8_0010);
    u_dalu_cpu_model.set_mode(16'h0000, 16'h0000);
    op(DALU_OP_LOAD, DALU_SRC_SCALE, 1'b0, 1'b0, 5'h04, 4'h0, 16'h8001, 32'h0);
    chk(acc, 32'h0008_0010);
    op(DALU_OP_LOAD, DALU_SRC_SCALE, 1'b1, 1'b0, 5'h14, 4'h0, 16'h8001, 32'h0);
    chk(acc, 32'h8001_0000);
    $display("scale test done");
  endtask : t_scale
  task automatic t_alu();
    ld(32'h0f0f_0000);
    op(DALU_OP_SAVE_BUF, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(buff, 32'h0f0f_0000);
    ld(32'h00ff_ff00);
    op(DALU_OP_AND, DALU_SRC_BUFFER, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(acc, 32'h000f_0000);
    op(DALU_OP_OR, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h1);
    chk(acc, 32'h000f_0001);
    op(DALU_OP_XOR, DALU_SRC_SCALE, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0001, 32'h0);
    chk(acc, 32'h000f_0000);
    op(DALU_OP_ADD, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0000_ffff);
    chk(acc, 32'h000f_ffff);
    op(DALU_OP_SUB, DALU_SRC_BUFFER, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(acc, 32'hf100_ffff);
    op(DALU_OP_NOP, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h5);
    chk(acc, 32'hf100_ffff);
    $display("alu test done");
  endtask : t_alu
  task automatic t_dyn();
    // upper count bits set: only the low four may count
    u_dalu_cpu_model.set_mode(16'hfff3, 16'h0000);
    op(DALU_OP_LOAD, DALU_SRC_SCALE, 1'b0, 1'b1, 5'h10, 4'h0, 16'h0001, 32'h0);
    chk(acc, 32'h0000_0008);
    op(DALU_OP_ADD, DALU_SRC_SCALE, 1'b1, 1'b1, 5'h00, 4'h0, 16'h0002, 32'h0);
    chk(acc, 32'h0000_0018);
    op(DALU_OP_SUB, DALU_SRC_SCALE, 1'b0, 1'b1, 5'h00, 4'h0, 16'h0001, 32'h0);
    chk(acc, 32'h0000_0010);
    $display("dynamic shift test done");
  endtask : t_dyn
  task automatic t_shift();
    ld(32'h8000_0000);
    op(DALU_OP_RSHIFT, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'hf, 16'h0, 32'h0);
    chk(acc, 32'h0000_8000);
    op(DALU_OP_RSHIFT, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(acc, 32'h0000_4000);
    op(DALU_OP_NORMALISE_OP, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(acc, 32'h0000_8000);
    ld(32'h4000_0000);
    op(DALU_OP_NORMALISE_OP, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk(acc, 32'h4000_0000);
    $display("shift test done");
  endtask : t_shift
  task automatic t_store();
    logic [3:0] sh [3] = '{4'h4, 4'h7, 4'h0};
    logic hi [3] = '{1'b1, 1'b0, 1'b1};
    logic [15:0] exp [3] = '{16'h2345, 16'h3c00, 16'h1234};
    ld(32'h1234_5678);
    for (int i = 0; i < 3; i++) begin
      u_dalu_cpu_model.issue('0, '{1'b1, hi[i], sh[i][2:0]}, 16'h0, 32'h0);
      #1;
      chk({31'h0, svld}, 32'h1);
      chk(sdat_w, {16'h0000, exp[i]});
      @(posedge i_clk_sys);
      #1;
      chk({31'h0, svld}, 32'h0);
      chk(acc, 32'h1234_5678);
    end
    $display("store test done");
  endtask : t_store
  task automatic t_cmp();
    ld(32'hffff_fffd);
    op(DALU_OP_SAVE_BUF, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    ld(32'h0000_0005);
    op(DALU_OP_CMP_MIN, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk({31'h0, carry}, 32'h0);
    chk(acc, 32'hffff_fffd);
    chk(buff, 32'hffff_fffd);
    ld(32'hffff_fff9);
    op(DALU_OP_CMP_MIN, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk({31'h0, carry}, 32'h1);
    chk(acc, 32'hffff_fff9);
    chk(buff, 32'hffff_fff9);
    ld(32'h0000_0002);
    op(DALU_OP_CMP_MAX, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk({31'h0, carry}, 32'h1);
    chk(acc, 32'h0000_0002);
    chk(buff, 32'h0000_0002);
    ld(32'h0000_0001);
    op(DALU_OP_CMP_MAX, DALU_SRC_PRODUCT, 1'b0, 1'b0, 5'h00, 4'h0, 16'h0, 32'h0);
    chk({31'h0, carry}, 32'h0);
    chk(acc, 32'h0000_0002);
    chk(buff, 32'h0000_0002);
    $display("compare test done");
  endtask : t_cmp
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    #1;
    chk({30'h0, carry, svld}, 32'h0);
    chk(acc, 32'h0000_0000);
    chk(buff, 32'h0000_0000);
    t_scale();
    t_alu();
    t_dyn();
    t_shift();
    t_store();
    t_cmp();
    end_of_test();
  end
  // guard against a hung run
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule : dalu_datapath_test
`default_nettype wire
